// file: common/pm_csr_pkg.sv
// constants for the power management control/status register block
// assumes a 32-bit axi4-lite register bus and a 125 mhz function clock
package pm_csr_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [3:0]  PM_CSR_OFFSET   = 4'h4;   // control/status
    localparam logic [3:0]  PM_STRAP_OFFSET = 4'h8;   // capability view
    localparam int          ADDR_W          = 4;      // decoded addr bits

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int WAKE_FLAG_BIT   = 15;
    localparam int SCALE_HI        = 14;
    localparam int SCALE_LO        = 13;
    localparam int SELECT_HI       = 12;
    localparam int SELECT_LO       = 9;
    localparam int WAKE_EN_BIT     = 8;
    localparam int LEVEL_HI        = 1;
    localparam int LEVEL_LO        = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [3:0] SELECT_RESET = 4'h0;
    localparam logic [1:0] LEVEL_RESET  = 2'h0;
    localparam logic       WAKE_RESET   = 1'b0;

    // ****************************************************************
    // power levels
    // ****************************************************************
    localparam logic [1:0] LEVEL_D0   = 2'h0;
    localparam logic [1:0] LEVEL_D1   = 2'h1;
    localparam logic [1:0] LEVEL_D2   = 2'h2;
    localparam logic [1:0] LEVEL_D3H  = 2'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: core/pm_scale_table.sv
// scale lookup: registered scale factor per measurement select code
// assumes the select code comes from logic on the same clock
`timescale 1ns/100ps
module pm_scale_table
    import pm_csr_pkg::*;
#(
    parameter logic [31:0] SCALE_CODES = 32'h0000_0000 // 2 bits per code
)
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_select,
    output logic      [1:0] o_scale
);

    // ****************************************************************
    // registered read of the constant table
    // ****************************************************************
    // codes 0..15, two bits each; unused codes default to zero
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_scale <= 2'h0;
        end
        else
        begin
            o_scale <= SCALE_CODES[{i_select, 1'b0} +: 2];
        end
    end

endmodule

// file: core/power_mgmt_control_status.sv
// power management control/status register with wake-event logic
// assumes an axi4-lite master, an async status-change source pin,
// and a slot reset pin that may or may not touch the wake context
//
// How it works
// - one 16-bit register holds all fields
// - sticky wake bits ignore power-on and d3cold
// - sticky bits clear only by write, vaux or non-capable bus reset
// - in d0 as in d1-d3, enable gates only the output
// - in d1-d3 no output without enable
// - wake context survives d3hot, and slot reset only when d3cold capable
// - without d3cold wake, bus reset clears context
// - flag sets on wake event regardless of enable
// - write one clears flag, zero keeps it
// - flag resets to zero unless d3cold capable
// - bits 14:13 read-only scale, follows select
// - bits 12:9 select, read/write, resets zero
// - bit 8 enable permits status-change drive
// - bits 1:0 power level, resets to d0
// - unsupported level write discarded, bus okay
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module power_mgmt_control_status
    import pm_csr_pkg::*;
#(
    parameter bit          D3COLD_WAKE = 1'b1,   // wake from d3cold
    parameter bit          D1_SUPPORT  = 1'b1,   // d1 implemented
    parameter bit          D2_SUPPORT  = 1'b0,   // d2 implemented
    parameter logic [31:0] SCALE_CODES = 32'h0000_0000
)
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,            // aux supply loss reset
    input  wire logic        i_card_slot_reset, // slot/bus reset, hi
    input  wire logic        i_wake_source,    // async wake event pin
    output logic             o_card_status_change_out,
    output logic       [1:0] o_current_power_level,
    output logic       [3:0] o_measure_select,
    // axi4-lite write address
    input  wire logic [31:0] i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic  [3:0] i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    // axi4-lite write response
    output logic       [1:0] o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    // axi4-lite read address
    input  wire logic [31:0] i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    // axi4-lite read data
    output logic      [31:0] o_s_axi_rdata,
    output logic       [1:0] o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic        wake_sync1;        // first synchroniser stage
    logic        wake_sync2;        // second synchroniser stage
    logic        wake_prev;         // for rising-edge detection
    logic        wake_event;        // one-cycle event pulse
    logic        slot_sync1;        // slot reset synchroniser
    logic        slot_sync2;        // synchronised slot reset
    logic        wake_event_flag;   // sticky status
    logic        wake_event_enable; // sticky enable
    logic  [3:0] measure_select;    // measurement select field
    logic  [1:0] scale;             // registered scale factor
    logic  [1:0] current_power_level;
    logic        aw_held;           // write address captured
    logic        w_held;            // write data captured
    logic [ADDR_W-1:0] aw_addr;     // captured write address
    logic [31:0] w_data;            // captured write data
    logic  [3:0] w_strb;            // captured write strobes
    logic        wr_fire;           // write performed this cycle
    logic        wr_csr;            // write hits the csr
    logic        wr_lo;             // low byte lane written
    logic        wr_hi;             // high byte lane written
    logic        context_clear;     // wake flag/enable reset, non-capable only
    logic [15:0] csr_word;          // assembled csr read view
    logic        level_ok;          // requested level supported
    logic  [1:0] req_level;         // requested level

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // wake pin and slot reset come from outside this clock domain
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wake_sync1 <= 1'b0;
            wake_sync2 <= 1'b0;
            wake_prev  <= 1'b0;
            slot_sync1 <= 1'b0;
            slot_sync2 <= 1'b0;
        end
        else
        begin
            wake_sync1 <= i_wake_source;
            wake_sync2 <= wake_sync1;
            wake_prev  <= wake_sync2;
            slot_sync1 <= i_card_slot_reset;
            slot_sync2 <= slot_sync1;
        end
    end

    // wake detection is a rising edge of the synchronised source
    assign wake_event = wake_sync2 & ~wake_prev;

    // non-capable functions lose all wake context on a bus reset
    assign context_clear = slot_sync2 & ~D3COLD_WAKE;

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    // address and data are caught independently, in either order
    assign o_s_axi_awready = ~aw_held & ~o_s_axi_bvalid;
    assign o_s_axi_wready  = ~w_held & ~o_s_axi_bvalid;
    assign wr_fire         = aw_held & w_held & ~o_s_axi_bvalid;
    assign wr_csr          = wr_fire & (aw_addr == PM_CSR_OFFSET);
    assign wr_lo           = wr_csr & w_strb[0];
    assign wr_hi           = wr_csr & w_strb[1];

    // capture address and data halves of a write
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (i_s_axi_awvalid && o_s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr[ADDR_W-1:0];
            end
            else if (wr_fire)
            begin
                aw_held <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_held <= 1'b0;
            end
        end
    end

    // write response: okay for mapped words, slverr otherwise
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            o_s_axi_bvalid <= 1'b1;
            // discarded level writes still answer okay
            o_s_axi_bresp  <= (aw_addr == PM_CSR_OFFSET ||
                               aw_addr == PM_STRAP_OFFSET)
                              ? RESP_OKAY : RESP_SLVERR;
        end
        else if (i_s_axi_bready)
        begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // wake-event flag and enable
    // ****************************************************************
    // i_rst stands for loss of every supply including aux, so it
    // clears both; slot reset only clears non-capable functions
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wake_event_flag <= WAKE_RESET;
        end
        else if (context_clear)
        begin
            wake_event_flag <= 1'b0;
        end
        else if (wake_event)
        begin
            // event wins over a clearing write
            wake_event_flag <= 1'b1;
        end
        else if (wr_hi && w_data[WAKE_FLAG_BIT])
        begin
            // write one clears, zero leaves it
            wake_event_flag <= 1'b0;
        end
    end

    // enable is a plain read/write bit, sticky like the flag
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wake_event_enable <= WAKE_RESET;
        end
        else if (context_clear)
        begin
            wake_event_enable <= 1'b0;
        end
        else if (wr_hi)
        begin
            wake_event_enable <= w_data[WAKE_EN_BIT];
        end
    end

    // ****************************************************************
    // status-change output
    // ****************************************************************
    // drive only while flag and enable are both set; in d0 the
    // enable adds nothing else, in d1-d3 nothing without it
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_card_status_change_out <= 1'b0;
        end
        else
        begin
            o_card_status_change_out <= wake_event_flag &
                                        wake_event_enable &
                                        ~(wr_hi && w_data[WAKE_FLAG_BIT]);
        end
    end

    // ****************************************************************
    // measurement select and scale
    // ****************************************************************
    // select is ordinary context, reset by either reset
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            measure_select <= SELECT_RESET;
        end
        else if (slot_sync2)
        begin
            measure_select <= SELECT_RESET;
        end
        else if (wr_hi || wr_lo)
        begin
            // select sits in the high byte lane; still needs both strobes
            if (w_strb[0] && w_strb[1])
            begin
                measure_select <= w_data[SELECT_HI:SELECT_LO];
            end
        end
    end

    // scale follows the select one cycle later
    pm_scale_table #(
        .SCALE_CODES (SCALE_CODES)
    ) u_scale (
        .i_mclk   (i_mclk),
        .i_rst    (i_rst),
        .i_select (measure_select),
        .o_scale  (scale)
    );

    // ****************************************************************
    // power level
    // ****************************************************************
    assign req_level = w_data[LEVEL_HI:LEVEL_LO];

    // optional levels d1 and d2 only when implemented
    always_comb
    begin
        unique case (req_level)
            LEVEL_D1 : level_ok = D1_SUPPORT;
            LEVEL_D2 : level_ok = D2_SUPPORT;
            default  : level_ok = 1'b1;
        endcase
    end

    // level register; unsupported requests are dropped
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            current_power_level <= LEVEL_RESET;
        end
        else if (slot_sync2)
        begin
            current_power_level <= LEVEL_RESET;
        end
        else if (wr_lo && level_ok)
        begin
            current_power_level <= req_level;
        end
    end

    assign o_current_power_level = current_power_level;
    assign o_measure_select      = measure_select;

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    // 16-bit csr view, reserved bits zero
    always_comb
    begin
        csr_word                          = 16'h0000;
        csr_word[WAKE_FLAG_BIT]           = wake_event_flag;
        csr_word[SCALE_HI:SCALE_LO]       = scale;
        csr_word[SELECT_HI:SELECT_LO]     = measure_select;
        csr_word[WAKE_EN_BIT]             = wake_event_enable;
        csr_word[LEVEL_HI:LEVEL_LO]       = current_power_level;
    end

    assign o_s_axi_arready = ~o_s_axi_rvalid;

    // one read at a time; answer registered one cycle after address
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0000_0000;
            o_s_axi_rresp  <= RESP_OKAY;
        end
        else if (i_s_axi_arvalid && o_s_axi_arready)
        begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp  <= RESP_OKAY;
            if (i_s_axi_araddr[ADDR_W-1:0] == PM_CSR_OFFSET)
            begin
                o_s_axi_rdata <= {16'h0000, csr_word};
            end
            else if (i_s_axi_araddr[ADDR_W-1:0] == PM_STRAP_OFFSET)
            begin
                // capability view: d3cold wake, d2, d1
                o_s_axi_rdata <= {29'h0000_0000, D3COLD_WAKE,
                                  D2_SUPPORT, D1_SUPPORT};
            end
            else
            begin
                o_s_axi_rdata <= 32'h0000_0000;
                o_s_axi_rresp <= RESP_SLVERR;
            end
        end
        else if (i_s_axi_rready)
        begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// file: testbench/host_sw_model.sv
// host software model: axi4-lite master for register accesses
// assumes one clock, requests start after reset release
`timescale 1ns/100ps
module host_sw_model
(
    input  wire logic        i_mclk,
    output logic      [31:0] o_awaddr,
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic      [31:0] o_wdata,
    output logic             o_wvalid,
    input  wire logic        i_wready,
    input  wire logic  [1:0] i_bresp,
    input  wire logic        i_bvalid,
    output logic             o_bready,
    output logic      [31:0] o_araddr,
    output logic             o_arvalid,
    input  wire logic        i_arready,
    input  wire logic [31:0] i_rdata,
    input  wire logic  [1:0] i_rresp,
    input  wire logic        i_rvalid,
    output logic             o_rready
);
    // idle values at time zero
    initial
    begin
        {o_awaddr, o_wdata, o_araddr} = '0;
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = '0;
    end
    // one write, address and data offered together, each released
    // at the edge that takes it
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge i_mclk);
        o_awaddr <= a;
        o_wdata <= d;
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge i_mclk);
            if (!aw_done && i_awready)
            begin
                aw_done = 1'b1;
                o_awvalid <= 1'b0;
                o_awaddr <= ~a;     // released payload is not kept
            end
            if (!w_done && i_wready)
            begin
                w_done = 1'b1;
                o_wvalid <= 1'b0;
                o_wdata <= ~d;
            end
        end
        do @(posedge i_mclk); while (!i_bvalid);
        r = i_bresp;
        o_bready <= 1'b0;
    endtask
    // one read
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge i_mclk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        do @(posedge i_mclk); while (!i_arready);
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
        do @(posedge i_mclk); while (!i_rvalid);
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
    endtask
    // boot clean-up: enable off, flag cleared
    task automatic boot(output logic [1:0] r);
        wr(32'h4, 32'h8000, r);
    endtask
endmodule

// file: testbench/power_mgmt_props.sv
// assertion checker for the power management register block
// assumes a bind onto the top module ports, one clock domain
`timescale 1ns/100ps
module power_mgmt_props
    import pm_csr_pkg::*;
#(
    parameter bit D2_SUPPORT = 1'b0
)
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_card_slot_reset,
    input wire logic        o_card_status_change_out,
    input wire logic [1:0]  o_current_power_level,
    input wire logic [3:0]  o_measure_select,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic [31:0] i_s_axi_araddr,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [1:0]  o_s_axi_rresp,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready
);
    // ****************************************************************
    // helper handshakes
    // ****************************************************************
    logic aw_hs;    // write address taken
    logic w_hs;     // write data taken
    assign aw_hs = i_s_axi_awvalid && o_s_axi_awready;
    assign w_hs  = i_s_axi_wvalid && o_s_axi_wready;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // ****************************************************************
    // bus and register properties
    // ****************************************************************
    a_bresp_holds: assert property (
        o_s_axi_bvalid && !i_s_axi_bready |=>
        o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (
        o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped early");
    a_read_refused: assert property (
        o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read taken while data pending");
    a_write_refused: assert property (
        o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken while response pending");
    a_unmapped_read: assert property (
        i_s_axi_arvalid && o_s_axi_arready &&
        i_s_axi_araddr[3:0] != 4'h4 && i_s_axi_araddr[3:0] != 4'h8 |=>
        o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_slot_clears: assert property (
        i_card_slot_reset [*5] |->
        o_measure_select == 4'h0 && o_current_power_level == 2'h0)
        else $error("slot reset left select or level");
    a_level_cause: assert property (
        $changed(o_current_power_level) |->
        $past(w_hs, 2) || $past(aw_hs, 2) ||
        $past(i_card_slot_reset, 3) || $past(i_card_slot_reset, 4))
        else $error("power level moved without cause");
    a_level_legal: assert property (
        !(!D2_SUPPORT && o_current_power_level == LEVEL_D2))
        else $error("unsupported power level reached");
    a_out_fall_cause: assert property (
        $fell(o_card_status_change_out) |->
        $past(w_hs, 2) || $past(w_hs, 3) ||
        $past(aw_hs, 2) || $past(aw_hs, 3))
        else $error("status change output fell without write");
    // main scenarios seen
    c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
    c_wake: cover property ($rose(o_card_status_change_out));
    c_slverr: cover property (o_s_axi_rvalid &&
        o_s_axi_rresp == RESP_SLVERR);
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the power management register block
// assumes the host model drives the bus, bench drives pins
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); \
    end end
module tb_top;
    import pm_csr_pkg::*;
    localparam logic [31:0] SCALES = 32'h1b6c_e4d2; // scale table
    logic i_mclk = 0, i_rst = 1, i_card_slot_reset = 0, i_wake_source = 0;
    logic o_out, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
    logic [1:0] o_lvl, b_resp, r_resp, resp;
    logic [3:0] o_sel;
    logic [31:0] aw_a, w_d, ar_a, r_d, rdat;
    int num_errors = 0, n_compared = 0;
    int m_flag, m_en, m_sel, m_lvl;   // behavioural register model
    always #4 i_mclk = ~i_mclk;
    power_mgmt_control_status #(.SCALE_CODES(SCALES)) dut (
        .i_mclk, .i_rst, .i_card_slot_reset, .i_wake_source,
        .o_card_status_change_out(o_out), .o_current_power_level(o_lvl),
        .o_measure_select(o_sel), .i_s_axi_awaddr(aw_a),
        .i_s_axi_awvalid(aw_v), .o_s_axi_awready(aw_r),
        .i_s_axi_wdata(w_d), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(w_v),
        .o_s_axi_wready(w_r), .o_s_axi_bresp(b_resp), .o_s_axi_bvalid(b_v),
        .i_s_axi_bready(b_r), .i_s_axi_araddr(ar_a), .i_s_axi_arvalid(ar_v),
        .o_s_axi_arready(ar_r), .o_s_axi_rdata(r_d), .o_s_axi_rresp(r_resp),
        .o_s_axi_rvalid(r_v), .i_s_axi_rready(r_r));
    host_sw_model host (
        .i_mclk, .o_awaddr(aw_a), .o_awvalid(aw_v), .i_awready(aw_r),
        .o_wdata(w_d), .o_wvalid(w_v), .i_wready(w_r), .i_bresp(b_resp),
        .i_bvalid(b_v), .o_bready(b_r), .o_araddr(ar_a), .o_arvalid(ar_v),
        .i_arready(ar_r), .i_rdata(r_d), .i_rresp(r_resp), .i_rvalid(r_v),
        .o_rready(r_r));
    // expected register word from the model
    function automatic logic [31:0] exp_csr();
        return {16'h0, 1'(m_flag), SCALES[2*m_sel+:2], 4'(m_sel),
                1'(m_en), 6'h0, 2'(m_lvl)};
    endfunction
    // write the register and update the model
    task automatic wrc(input logic [31:0] d);
        host.wr(32'h4, d, resp);
        `CHK(resp, RESP_OKAY)
        if (d[15]) m_flag = 0;
        m_en = d[8];
        m_sel = d[12:9];
        if (d[1:0] != LEVEL_D2) m_lvl = d[1:0];
    endtask
    task automatic chk_csr();
        host.rd(32'h4, rdat, resp);
        `CHK(rdat, exp_csr())
    endtask
    task automatic wake();
        i_wake_source <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_wake_source <= 1'b0;
        repeat (8) @(posedge i_mclk);
    endtask
    task automatic results();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        results();
    end
    initial
    begin
        void'($urandom(53823));
        {m_flag, m_en, m_sel, m_lvl} = '0;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        chk_csr();
        host.rd(32'h8, rdat, resp);
        `CHK(rdat, 32'h5)
        host.rd(32'hc, rdat, resp);
        `CHK({rdat, resp}, {32'h0, RESP_SLVERR})
        host.wr(32'hc, 32'hffff, resp);
        `CHK(resp, RESP_SLVERR)
        for (int lv = 0; lv < 4; lv++)
        begin
            wrc(32'(lv));
            chk_csr();
            `CHK(o_lvl, 2'(m_lvl))
        end
        repeat (4)
        begin
            wrc({19'h0, 4'($urandom()), 9'h001});
            chk_csr();
            `CHK(o_sel, 4'(m_sel))
        end
        wake();
        m_flag = 1;
        `CHK(o_out, 1'b0)
        chk_csr();
        wrc(32'h0101);
        repeat (4) @(posedge i_mclk);
        `CHK(o_out, 1'b1)
        chk_csr();
        i_card_slot_reset <= 1'b1;
        repeat (6) @(posedge i_mclk);
        i_card_slot_reset <= 1'b0;
        repeat (4) @(posedge i_mclk);
        {m_sel, m_lvl} = '0;
        chk_csr();
        `CHK(o_out, 1'b1)
        wrc(32'h8100);
        repeat (4) @(posedge i_mclk);
        `CHK(o_out, 1'b0)
        chk_csr();
        wake();
        m_flag = 1;
        host.boot(resp);
        {m_flag, m_en} = '0;
        chk_csr();
        wrc(32'h0100);
        wake();
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        {m_flag, m_en, m_sel, m_lvl} = '0;
        chk_csr();
        `CHK(o_out, 1'b0)
        results();
    end
endmodule
bind power_mgmt_control_status power_mgmt_props #(
    .D2_SUPPORT(D2_SUPPORT)) u_props (
    .i_mclk, .i_rst, .i_card_slot_reset, .o_card_status_change_out,
    .o_current_power_level, .o_measure_select, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready);
